// [rcd_top.sv]
/*
 Radio command decoder: takes SPI bytes from the host, runs radio state
 changes, raises action pulses for the radio controller and drives a byte
 memory port for sequential and nonsequential accesses.
 Assumes the memory answers a read one clock after MEM_RE_O, the firmware
 residency flags come from logic on CLK_SYS_I, and STATUS_I is the status
 byte to shift out whenever no read data is due.
*/
`include "rcd_defines.svh"

module rcd_top import rcd_pkg::*; (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic ARST_N_I,
	// SPI pins
	input wire logic SPI_SCLK_I,
	input wire logic SPI_CS_N_I,
	input wire logic SPI_MOSI_I,
	output logic SPI_MISO_O,
	output logic SPI_MISO_OE_N_O,
	// Controller state and firmware residency
	input wire logic [7:0] STATUS_I,
	input wire logic FW_IMG_CAL_I,
	input wire logic FW_AES_I,
	input wire logic FW_RS_I,
	// Memory port
	input wire logic [7:0] MEM_RDATA_I,
	output logic MEM_WE_O,
	output logic MEM_RE_O,
	output logic [`RCD_ADDR_W-1:0] MEM_ADDR_O,
	output logic [7:0] MEM_WDATA_O,
	// Radio controller
	output rcd_radio_t RADIO_STATE_O,
	output logic SYNCED_O,
	output logic [`RCD_ACT_W-1:0] ACTION_O
);

	logic [7:0] rx_byte;
	logic rx_done;
	logic frame_start;
	logic frame_end;
	rcd_kind_t kind;

	rcd_seq_t seq_q;
	rcd_kind_t mode_q;
	logic [2:0] hi_q;
	logic [`RCD_ADDR_W-1:0] addr_q;
	logic [`RCD_ADDR_W-1:0] full_addr;
	logic rd_valid_q;
	logic [7:0] tx_byte_q;
	logic tx_load_q;
	logic op_radio;

	////////////////////////////////////////////////////////////////////////
	// Byte link and first-byte classifier

	rcd_spi_byte u_spi (
		.clk_i(CLK_SYS_I),
		.arst_n_i(ARST_N_I),
		.sclk_i(SPI_SCLK_I),
		.cs_n_i(SPI_CS_N_I),
		.mosi_i(SPI_MOSI_I),
		.miso_o(SPI_MISO_O),
		.miso_oe_n_o(SPI_MISO_OE_N_O),
		.tx_byte_i(tx_byte_q),
		.tx_load_i(tx_load_q),
		.rx_byte_o(rx_byte),
		.rx_done_o(rx_done),
		.frame_start_o(frame_start),
		.frame_end_o(frame_end)
	);

	rcd_opcode_class u_class (
		.byte_i(rx_byte),
		.kind_o(kind)
	);

	// Low address byte joins the three bits kept from the opcode
	assign full_addr = {hi_q, rx_byte};

	// A radio opcode counts only as the first byte of a command
	assign op_radio = rx_done && seq_q == SQ_OPCODE && kind == KIND_RADIO;

	////////////////////////////////////////////////////////////////////////
	// Access sequencer. Each byte in opcode position is decoded on its
	// own, so several one-byte commands may share one chip select.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			seq_q <= SQ_OPCODE;
			mode_q <= KIND_NONE;
			hi_q <= 3'h0;
		end else if (frame_end) begin
			seq_q <= SQ_OPCODE;
			mode_q <= KIND_NONE;
		end else if (rx_done) begin
			unique case (seq_q)
				SQ_OPCODE: begin
					if (kind inside {KIND_SEQ_WR, KIND_SEQ_RD,
							KIND_RND_WR, KIND_RND_RD}) begin
						seq_q <= SQ_ADDR;
						mode_q <= kind;
						hi_q <= rx_byte[2:0];
					end
				end
				SQ_ADDR: begin
					seq_q <= SQ_DATA;
				end
				SQ_DATA: begin
					if (mode_q inside {KIND_RND_WR, KIND_RND_RD}) begin
						seq_q <= SQ_ADDR;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory port: write on each data byte, read ahead of each filler byte
	// so the answer is ready before its first bit leaves.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			addr_q <= '0;
			MEM_ADDR_O <= '0;
			MEM_WDATA_O <= 8'h00;
			MEM_WE_O <= 1'b0;
			MEM_RE_O <= 1'b0;
		end else begin
			MEM_WE_O <= 1'b0;
			MEM_RE_O <= 1'b0;
			if (rx_done && !frame_end && seq_q == SQ_ADDR) begin
				unique case (mode_q)
					KIND_SEQ_RD: begin
						MEM_ADDR_O <= full_addr;
						MEM_RE_O <= 1'b1;
						addr_q <= full_addr + 11'h001;
					end
					KIND_RND_RD: begin
						MEM_ADDR_O <= full_addr;
						MEM_RE_O <= 1'b1;
					end
					default: begin
						addr_q <= full_addr;
					end
				endcase
			end else if (rx_done && !frame_end && seq_q == SQ_DATA) begin
				unique case (mode_q)
					KIND_SEQ_WR: begin
						MEM_ADDR_O <= addr_q;
						MEM_WDATA_O <= rx_byte;
						MEM_WE_O <= 1'b1;
						addr_q <= addr_q + 11'h001;
					end
					KIND_SEQ_RD: begin
						MEM_ADDR_O <= addr_q;
						MEM_RE_O <= 1'b1;
						addr_q <= addr_q + 11'h001;
					end
					KIND_RND_WR: begin
						MEM_ADDR_O <= addr_q;
						MEM_WDATA_O <= rx_byte;
						MEM_WE_O <= 1'b1;
					end
					default: begin
						MEM_RE_O <= 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply byte: status by default, replaced by read data when it lands.
	// Read data arrives later than the status load and so wins.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rd_valid_q <= 1'b0;
			tx_byte_q <= 8'h00;
			tx_load_q <= 1'b0;
		end else begin
			rd_valid_q <= MEM_RE_O;
			tx_load_q <= 1'b0;
			if (rd_valid_q) begin
				tx_byte_q <= MEM_RDATA_I;
				tx_load_q <= 1'b1;
			end else if (frame_start || rx_done) begin
				tx_byte_q <= STATUS_I;
				tx_load_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Radio state
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			RADIO_STATE_O <= sleep_state;
		end else if (op_radio) begin
			unique case (rx_byte)
				`RCD_OP_OFF: RADIO_STATE_O <= radio_off_state;
				`RCD_OP_IDLE: RADIO_STATE_O <= radio_idle_state;
				`RCD_OP_RX: RADIO_STATE_O <= receive_state;
				`RCD_OP_TX: RADIO_STATE_O <= transmit_state;
				`RCD_OP_SLEEP: RADIO_STATE_O <= sleep_state;
				`RCD_OP_HW_RESET: RADIO_STATE_O <= sleep_state;
				default: RADIO_STATE_O <= RADIO_STATE_O;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync flag: lost whenever the processor is reset, so the host must
	// sync again after a full reset or a finished download.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			SYNCED_O <= 1'b0;
		end else if (op_radio) begin
			if (rx_byte == `RCD_OP_SYNC) begin
				SYNCED_O <= 1'b1;
			end else if (rx_byte inside {`RCD_OP_HW_RESET, `RCD_OP_LOAD_DONE}) begin
				SYNCED_O <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One-cycle action pulses for the radio controller. Module opcodes
	// follow whichever module is resident; encryption is tried first.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ACTION_O <= '0;
		end else begin
			ACTION_O <= '0;
			if (op_radio) begin
				unique case (rx_byte)
					`RCD_OP_SYNC: ACTION_O[`RCD_ACT_SYNC] <= 1'b1;
					`RCD_OP_CONFIG: ACTION_O[`RCD_ACT_CONFIG] <= 1'b1;
					`RCD_OP_RSSI: ACTION_O[`RCD_ACT_RSSI] <= 1'b1;
					`RCD_OP_IFCAL: ACTION_O[`RCD_ACT_IFCAL] <= 1'b1;
					`RCD_OP_HW_RESET: ACTION_O[`RCD_ACT_HW_RESET] <= 1'b1;
					`RCD_OP_LOAD_INIT: ACTION_O[`RCD_ACT_LOAD_INIT] <= 1'b1;
					`RCD_OP_LOAD_DONE: ACTION_O[`RCD_ACT_CP_RESET] <= 1'b1;
					`RCD_OP_IRCAL: ACTION_O[`RCD_ACT_IRCAL] <= FW_IMG_CAL_I;
					`RCD_OP_MOD_ENC: begin
						ACTION_O[`RCD_ACT_ENCRYPT] <= FW_AES_I;
						ACTION_O[`RCD_ACT_FEC_ENC] <= FW_RS_I & ~FW_AES_I;
					end
					`RCD_OP_MOD_INIT: begin
						ACTION_O[`RCD_ACT_DEC_SETUP] <= FW_AES_I;
						ACTION_O[`RCD_ACT_FEC_SETUP] <= FW_RS_I & ~FW_AES_I;
					end
					`RCD_OP_MOD_DEC: begin
						ACTION_O[`RCD_ACT_DECRYPT] <= FW_AES_I;
						ACTION_O[`RCD_ACT_FEC_DEC] <= FW_RS_I & ~FW_AES_I;
					end
					default: ACTION_O <= '0;
				endcase
			end
		end
	end

endmodule : rcd_top

// [rcd_defines.svh]
/*
 Opcode values, access patterns, action bit positions and timing counts
 of the radio command decoder. Assumes it is included by bare name.
*/
// Function
// - Sync opcode after reset brings the communications processor into step.
// - Radio-off opcode enters off state; radio-on opcode enters idle state.
// - Receive opcode enters receive state; transmit opcode enters transmit state.
// - Sleep opcode enters low-power sleep state.
// - Configure opcode applies radio settings from battery-backed memory.
// - Signal strength opcode runs one measurement.
// - Filter calibration opcode calibrates the intermediate-frequency filter.
// - Full reset opcode resets the hardware and leaves it asleep.
// - Load-init opcode prepares program RAM for a firmware download.
// - Load-done opcode after download resets the communications processor.
// - Image reject calibration runs only with its firmware module resident.
// - With encryption module, encrypt and decrypt act on payload in packet RAM.
// - With encryption module, decrypt-setup opcode initialises decryption variables.
// - Encryption opcodes do nothing with neither encryption nor coding module loaded.
// - With coding module, setup initialises encoding; encode appends check bytes.
// - With coding module, decode corrects errors; meaning follows resident module.
// - Memory address is 11 bits: top three in opcode, low eight next byte.
// - Sequential write data follows low address and fills consecutive locations.
// - Sequential read: opcode 00111xxx, low address, then one filler per byte.
// - Nonsequential writes use 00001xxx and nonsequential reads use 00101xxx.
// - Byte 0xff is no operation, for status polling and read filler.
`ifndef RCD_DEFINES_SVH
`define RCD_DEFINES_SVH

`define RCD_OP_SYNC 8'ha2
`define RCD_OP_OFF 8'hb0
`define RCD_OP_IDLE 8'hb1
`define RCD_OP_RX 8'hb2
`define RCD_OP_TX 8'hb5
`define RCD_OP_SLEEP 8'hba
`define RCD_OP_CONFIG 8'hbb
`define RCD_OP_RSSI 8'hbc
`define RCD_OP_IRCAL 8'hbd
`define RCD_OP_IFCAL 8'hbe
`define RCD_OP_LOAD_INIT 8'hbf
`define RCD_OP_LOAD_DONE 8'hc7
`define RCD_OP_HW_RESET 8'hc8
`define RCD_OP_MOD_ENC 8'hd0
`define RCD_OP_MOD_INIT 8'hd1
`define RCD_OP_MOD_DEC 8'hd2
`define RCD_OP_NOP 8'hff

`define RCD_PAT_SEQ_WR 5'h03
`define RCD_PAT_SEQ_RD 5'h07
`define RCD_PAT_RND_WR 5'h01
`define RCD_PAT_RND_RD 5'h05

`define RCD_ACT_W 14
`define RCD_ACT_SYNC 0
`define RCD_ACT_CONFIG 1
`define RCD_ACT_RSSI 2
`define RCD_ACT_IFCAL 3
`define RCD_ACT_LOAD_INIT 4
`define RCD_ACT_CP_RESET 5
`define RCD_ACT_HW_RESET 6
`define RCD_ACT_IRCAL 7
`define RCD_ACT_ENCRYPT 8
`define RCD_ACT_DEC_SETUP 9
`define RCD_ACT_DECRYPT 10
`define RCD_ACT_FEC_SETUP 11
`define RCD_ACT_FEC_ENC 12
`define RCD_ACT_FEC_DEC 13

`define RCD_ADDR_W 11
`define RCD_SYNC_STAGES 2

`endif

// [rcd_pkg.sv]
/*
 Types shared by the radio command decoder modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rcd_pkg;

	typedef enum logic [2:0] {
		radio_off_state,
		radio_idle_state,
		receive_state,
		transmit_state,
		sleep_state
	} rcd_radio_t;

	typedef enum logic [2:0] {
		KIND_RADIO,
		KIND_SEQ_WR,
		KIND_SEQ_RD,
		KIND_RND_WR,
		KIND_RND_RD,
		KIND_NOP,
		KIND_NONE
	} rcd_kind_t;

	typedef enum logic [1:0] {
		SQ_OPCODE,
		SQ_ADDR,
		SQ_DATA
	} rcd_seq_t;

endpackage : rcd_pkg

// [rcd_spi_byte.sv]
/*
 SPI mode 0 byte slave, oversampled by the system clock.
 Assumes the pins are asynchronous and SCLK half period spans at least
 twelve system clocks, so a reply byte can be loaded between bytes.
*/
`include "rcd_defines.svh"

module rcd_spi_byte (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_n_o,
	// Byte side
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_load_i,
	output logic [7:0] rx_byte_o,
	output logic rx_done_o,
	output logic frame_start_o,
	output logic frame_end_o
);

	// Idle pin levels {sclk, cs_n, mosi}; the synchroniser resets to them
	// so no false chip-select or clock edge follows reset
	localparam logic [2:0] PIN_IDLE = 3'b010;

	logic [2:0] pins;
	logic [2:0] pin_a_q;
	logic [2:0] pin_b_q;
	logic sclk_d_q;
	logic cs_n_d_q;
	logic [2:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic active;
	logic rise;
	logic fall;

	assign pins = {sclk_i, cs_n_i, mosi_i};

	////////////////////////////////////////////////////////////////////////
	// First stage feeds only the second stage
	generate
		for (genvar g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					pin_a_q[g] <= PIN_IDLE[g];
					pin_b_q[g] <= PIN_IDLE[g];
				end else begin
					pin_a_q[g] <= pins[g];
					pin_b_q[g] <= pin_a_q[g];
				end
			end
		end
	endgenerate

	assign active = ~pin_b_q[1];
	assign rise = pin_b_q[2] & ~sclk_d_q;
	assign fall = ~pin_b_q[2] & sclk_d_q;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_d_q <= 1'b0;
			cs_n_d_q <= 1'b1;
			frame_start_o <= 1'b0;
			frame_end_o <= 1'b0;
		end else begin
			sclk_d_q <= pin_b_q[2];
			cs_n_d_q <= pin_b_q[1];
			frame_start_o <= cs_n_d_q & ~pin_b_q[1];
			frame_end_o <= ~cs_n_d_q & pin_b_q[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive shifter
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= 3'h0;
			sh_q <= 8'h00;
			rx_byte_o <= 8'h00;
			rx_done_o <= 1'b0;
		end else begin
			rx_done_o <= 1'b0;
			if (!active) begin
				cnt_q <= 3'h0;
			end else if (rise) begin
				sh_q <= {sh_q[6:0], pin_b_q[0]};
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q == 3'h7) begin
					rx_byte_o <= {sh_q[6:0], pin_b_q[0]};
					rx_done_o <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit shifter; the falling edge at a byte boundary is skipped
	// because the next byte's first bit is already presented by the load.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_q <= 8'h00;
			miso_o <= 1'b0;
			miso_oe_n_o <= 1'b1;
		end else begin
			miso_oe_n_o <= ~active;
			if (tx_load_i) begin
				tx_q <= tx_byte_i;
				miso_o <= tx_byte_i[7];
			end else if (active && fall && cnt_q != 3'h0) begin
				tx_q <= {tx_q[6:0], 1'b0};
				miso_o <= tx_q[6];
			end
		end
	end

endmodule : rcd_spi_byte

// [rcd_opcode_class.sv]
/*
 Classifies a first byte into radio command, memory access, filler or unknown.
 Pure combinational; assumes the caller only looks at it on a first byte.
*/
`include "rcd_defines.svh"

module rcd_opcode_class import rcd_pkg::*; (
	// Byte in, class out
	input wire logic [7:0] byte_i,
	output rcd_kind_t kind_o
);

	always_comb begin
		kind_o = KIND_NONE;
		unique case (byte_i[7:3])
			`RCD_PAT_SEQ_WR: kind_o = KIND_SEQ_WR;
			`RCD_PAT_SEQ_RD: kind_o = KIND_SEQ_RD;
			`RCD_PAT_RND_WR: kind_o = KIND_RND_WR;
			`RCD_PAT_RND_RD: kind_o = KIND_RND_RD;
			default: begin
				if (byte_i == `RCD_OP_NOP) begin
					kind_o = KIND_NOP;
				end else if (byte_i inside {`RCD_OP_SYNC, `RCD_OP_OFF,
						`RCD_OP_IDLE, `RCD_OP_RX, `RCD_OP_TX, `RCD_OP_SLEEP,
						`RCD_OP_CONFIG, `RCD_OP_RSSI, `RCD_OP_IRCAL,
						`RCD_OP_IFCAL, `RCD_OP_LOAD_INIT, `RCD_OP_LOAD_DONE,
						`RCD_OP_HW_RESET, `RCD_OP_MOD_ENC, `RCD_OP_MOD_INIT,
						`RCD_OP_MOD_DEC}) begin
					kind_o = KIND_RADIO;
				end
			end
		endcase
	end

endmodule : rcd_opcode_class

// [rcd_top_asserts.sv]
/*
 Port checks of the radio command decoder.
 Assumes one clock domain and a bind onto rcd_top.
*/
`include "rcd_defines.svh"

module rcd_top_asserts import rcd_pkg::*; (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic ARST_N_I,
	// Watched ports
	input wire logic SPI_CS_N_I,
	input wire logic FW_IMG_CAL_I,
	input wire logic FW_AES_I,
	input wire logic FW_RS_I,
	input wire logic MEM_WE_O,
	input wire logic MEM_RE_O,
	input wire rcd_radio_t RADIO_STATE_O,
	input wire logic SYNCED_O,
	input wire logic [`RCD_ACT_W-1:0] ACTION_O
);
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!ARST_N_I);
	////////////////////////////////////////////////////////////////////////////////
	// Eight idle cycles outlast the pin synchronisers, so nothing may still be due
	sequence s_cs_idle;
		SPI_CS_N_I [*8];
	endsequence
	sequence s_we_once;
		MEM_WE_O ##1 !MEM_WE_O;
	endsequence
	property p_we_pulse;
		MEM_WE_O |-> s_we_once;
	endproperty
	property p_act_pulse;
		ACTION_O != '0 |=> ACTION_O == '0;
	endproperty
	property p_sync_rise;
		$rose(SYNCED_O) |-> ACTION_O[`RCD_ACT_SYNC];
	endproperty
	property p_hw_reset;
		ACTION_O[`RCD_ACT_HW_RESET] |-> RADIO_STATE_O == sleep_state && !SYNCED_O;
	endproperty
	property p_cp_reset;
		ACTION_O[`RCD_ACT_CP_RESET] |-> !SYNCED_O;
	endproperty
	property p_ircal_gate;
		ACTION_O[`RCD_ACT_IRCAL] |-> $past(FW_IMG_CAL_I);
	endproperty
	property p_aes_gate;
		|ACTION_O[`RCD_ACT_DECRYPT:`RCD_ACT_ENCRYPT] |-> $past(FW_AES_I);
	endproperty
	property p_rs_gate;
		|ACTION_O[`RCD_ACT_FEC_DEC:`RCD_ACT_FEC_SETUP] |-> $past(FW_RS_I) && !$past(FW_AES_I);
	endproperty
	property p_quiet_idle;
		s_cs_idle |-> !MEM_WE_O && !MEM_RE_O && ACTION_O == '0;
	endproperty
	////////////////////////////////////////////////////////////////////////////////
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
	a_act_pulse: assert property (p_act_pulse) else $error("action too long");
	a_sync_rise: assert property (p_sync_rise) else $error("sync without action");
	a_hw_reset: assert property (p_hw_reset) else $error("full reset not asleep");
	a_cp_reset: assert property (p_cp_reset) else $error("sync kept");
	a_ircal_gate: assert property (p_ircal_gate) else $error("image cal ungated");
	a_aes_gate: assert property (p_aes_gate) else $error("cipher ungated");
	a_rs_gate: assert property (p_rs_gate) else $error("coding ungated");
	a_quiet_idle: assert property (p_quiet_idle) else $error("activity while idle");
endmodule : rcd_top_asserts

bind rcd_top rcd_top_asserts rcd_top_asserts_i (
	.CLK_SYS_I(CLK_SYS_I),
	.ARST_N_I(ARST_N_I),
	.SPI_CS_N_I(SPI_CS_N_I),
	.FW_IMG_CAL_I(FW_IMG_CAL_I),
	.FW_AES_I(FW_AES_I),
	.FW_RS_I(FW_RS_I),
	.MEM_WE_O(MEM_WE_O),
	.MEM_RE_O(MEM_RE_O),
	.RADIO_STATE_O(RADIO_STATE_O),
	.SYNCED_O(SYNCED_O),
	.ACTION_O(ACTION_O)
);

// [rcd_host.sv]
/*
 Host model: SPI mode 0 master sending whole frames, MSB first.
 Assumes the bench calls send_frame and drives on falling clock edges.
*/
module rcd_host (
	// Clock
	input wire logic clk_i,
	// SPI pins
	input wire logic miso_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Stays above the slave's twelve-clock floor per half period
	localparam int HALF = 15;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	task automatic half();
		repeat (HALF) @(negedge clk_i);
	endtask : half
	task automatic send_frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
		logic [7:0] b;
		rx = {};
		@(negedge clk_i);
		cs_n_o = 1'b0;
		foreach (tx[k]) begin
			for (int i = 7; i >= 0; i--) begin
				mosi_o = tx[k][i];
				half();
				sclk_o = 1'b1;
				b[i] = miso_i;
				half();
				sclk_o = 1'b0;
			end
			rx.push_back(b);
		end
		half();
		cs_n_o = 1'b1;
		// Released line must not keep showing the last bit
		mosi_o = ~mosi_o;
		half();
	endtask : send_frame
endmodule : rcd_host

// [radio_command_decoder_test.sv]
/*
 Self-checking bench of the radio command decoder with a byte memory model.
 Assumes rcd_pkg, rcd_top, rcd_host and the checker are compiled first.
*/
module radio_command_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] op; logic [2:0] fw; int act; logic [2:0] st; logic syn;} rcd_row_t;
	logic clk, arst_n, sclk, cs_n, mosi, miso, miso_out, miso_oe_n, mem_we, mem_re, synced;
	logic miso_d = 1'b0;
	logic re_d = 1'b0;
	logic [2:0] fw;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata = 8'h00;
	logic [10:0] mem_addr;
	logic [13:0] action;
	logic [13:0] act_seen = '0;
	rcd_pkg::rcd_radio_t state;
	logic [7:0] mem [2048];
	logic [7:0] rx_q[$];
	logic [18:0] wq[$];
	int err_count, comparisons, cycles;
	// fw is {image cal, cipher, coding}; act -1 means no pulse
	rcd_row_t rows[26] = '{'{8'ha2, 0, 0, 4, 1}, '{8'hb0, 0, -1, 0, 1}, '{8'hb1, 0, -1, 1, 1},
		'{8'hb2, 0, -1, 2, 1}, '{8'hb5, 0, -1, 3, 1}, '{8'hba, 0, -1, 4, 1}, '{8'hbb, 0, 1, 4, 1},
		'{8'hbc, 0, 2, 4, 1}, '{8'hbe, 0, 3, 4, 1}, '{8'hbf, 0, 4, 4, 1}, '{8'hbd, 4, 7, 4, 1},
		'{8'hbd, 0, -1, 4, 1}, '{8'hd0, 2, 8, 4, 1}, '{8'hd1, 2, 9, 4, 1}, '{8'hd2, 2, 10, 4, 1},
		'{8'hd0, 1, 12, 4, 1}, '{8'hd1, 1, 11, 4, 1}, '{8'hd2, 1, 13, 4, 1}, '{8'hd0, 3, 8, 4, 1},
		'{8'hd1, 0, -1, 4, 1}, '{8'hff, 0, -1, 4, 1}, '{8'h55, 0, -1, 4, 1}, '{8'hb2, 0, -1, 2, 1},
		'{8'hc8, 0, 6, 4, 0}, '{8'ha2, 0, 0, 4, 1}, '{8'hc7, 0, 5, 4, 0}};
	////////////////////////////////////////////////////////////////////////////////
	rcd_top rcd_top_i (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n),
		.SPI_MOSI_I(mosi), .SPI_MISO_O(miso_out), .SPI_MISO_OE_N_O(miso_oe_n), .STATUS_I(8'h5a),
		.FW_IMG_CAL_I(fw[2]), .FW_AES_I(fw[1]), .FW_RS_I(fw[0]), .MEM_RDATA_I(mem_rdata),
		.MEM_WE_O(mem_we), .MEM_RE_O(mem_re), .MEM_ADDR_O(mem_addr), .MEM_WDATA_O(mem_wdata),
		.RADIO_STATE_O(state), .SYNCED_O(synced), .ACTION_O(action));
	rcd_host rcd_host_i (.clk_i(clk), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
	// Undriven reply line shows the inverse of its last driven bit
	assign miso = miso_oe_n ? ~miso_d : miso_out;
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		act_seen <= act_seen | action;
		if (!miso_oe_n) miso_d <= miso_out;
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
			wq.push_back({mem_addr, mem_wdata});
		end
		if (cycles == 40000) begin
			err_count++;
			give_verdict();
		end
	end
	// Read data held for two cycles, otherwise toggling
	always @(negedge clk) begin
		if (mem_re) mem_rdata <= mem[mem_addr];
		else if (!re_d) mem_rdata <= ~mem_rdata;
		re_d <= mem_re;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic frame(logic [7:0] tx[$]);
		@(negedge clk);
		act_seen = '0;
		wq = {};
		rcd_host_i.send_frame(tx, rx_q);
	endtask : frame
	task automatic give_verdict();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		fw = 3'h0;
		repeat (5) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		foreach (rows[r]) begin
			fw = rows[r].fw;
			frame({rows[r].op});
			check("action", rows[r].act < 0 ? 0 : 32'h1 << rows[r].act, act_seen);
			check("state", rows[r].st, state);
			check("synced", rows[r].syn, synced);
			check("status", 8'h5a, rx_q[0]);
			check("reply released", 1, miso_oe_n);
		end
		$display("test commands done");
		frame({8'h1b, 8'hfe, 8'ha1, 8'hb2, 8'hc3});
		check("write count", 3, wq.size());
		check("write 0", {11'h3fe, 8'ha1}, wq[0]);
		check("write 2", {11'h400, 8'hc3}, wq[2]);
		frame({8'h3b, 8'hfe, 8'hff, 8'hff, 8'hff});
		check("read 0", 8'ha1, rx_q[2]);
		check("read 2", 8'hc3, rx_q[4]);
		check("read writes", 0, wq.size());
		$display("test sequential done");
		frame({8'h09, 8'h20, 8'h11, 8'h40, 8'h22});
		check("nseq write 0", {11'h120, 8'h11}, wq[0]);
		check("nseq write 1", {11'h140, 8'h22}, wq[1]);
		frame({8'h29, 8'h20, 8'hff, 8'h40, 8'hff});
		check("nseq read 0", 8'h11, rx_q[2]);
		check("nseq read 1", 8'h22, rx_q[4]);
		$display("test nonsequential done");
		frame({8'h55, 8'h66, 8'h77});
		check("unknown writes", 0, wq.size());
		frame({8'hff, 8'hb0});
		check("poll status", 8'h5a, rx_q[1]);
		check("state after filler", 0, state);
		arst_n = 1'b0;
		repeat (2) @(negedge clk);
		check("reset state", 4, state);
		check("reset synced", 0, synced);
		check("reset reply off", 1, miso_oe_n);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		frame({8'ha2});
		check("resync", 1, synced);
		$display("test reset done");
		give_verdict();
	end
endmodule : radio_command_decoder_test
